// ### rtcca_calendar.sv
// calendar month and year counters with alarm compare, behind a byte register port
`timescale 1ns/100ps
module rtcca_calendar
  import rtcca_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire rtcca_pkg::rtcca_bus_s  bus,
  output logic [7:0]             rdata,
  input  wire logic              day_carry,
  input  wire rtcca_pkg::rtcca_time_s now,
  output logic [7:0]             month_out,
  output logic [7:0]             year_out,
  output logic                   leap_year,
  output logic                   irq
);
  import rtcca_pkg::*;

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic is_bcd(input logic [7:0] v, input logic [7:0] hi);
    return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v <= hi);
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] >= 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // ********************************************************
  // slow clock enable
  // ********************************************************
  logic [8:0] div_ff;
  logic       slow_tick;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_ff <= '0;
    end else if (div_ff == SLOW_DIV_LAST) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 9'h1;
    end
  end
  assign slow_tick = (div_ff == SLOW_DIV_LAST);

  // carry from day counter may come on any cycle; hold it until the next tick
  logic day_carry_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      day_carry_ff <= 1'b0;
    end else if (slow_tick) begin
      day_carry_ff <= day_carry;
    end else if (day_carry) begin
      day_carry_ff <= 1'b1;
    end
  end

  // ********************************************************
  // register writes and holding buffers
  // ********************************************************
  logic [7:0] month_ff, year_ff, alm_min_ff, alm_hour_ff, alm_wday_ff;
  logic [7:0] month_buf_ff, year_buf_ff;
  logic       month_pend_ff, year_pend_ff;
  logic       fmt24_ff;
  logic [2:0] irq_stat_ff, irq_mask_ff;
  logic       wr_month, wr_year;

  assign wr_month = bus.wr && (bus.addr == ADDR_MONTH);
  assign wr_year  = bus.wr && (bus.addr == ADDR_YEAR);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      month_buf_ff  <= RST_MONTH;
      year_buf_ff   <= RST_YEAR;
      month_pend_ff <= 1'b0;
      year_pend_ff  <= 1'b0;
    end else begin
      if (wr_month) begin
        month_buf_ff  <= bus.wdata & MONTH_MASK;
        month_pend_ff <= 1'b1;
      end else if (slow_tick) begin
        month_pend_ff <= 1'b0;
      end
      if (wr_year) begin
        year_buf_ff  <= bus.wdata;
        year_pend_ff <= 1'b1;
      end else if (slow_tick) begin
        year_pend_ff <= 1'b0;
      end
    end
  end

  // ********************************************************
  // month and year counters
  // ********************************************************
  logic month_wrap, year_wrap;
  logic [7:0] nxt_month, nxt_year;

  assign month_wrap = day_carry_ff && (month_ff == 8'h12);
  assign year_wrap  = month_wrap && (year_ff == 8'h99);

  always_comb begin
    nxt_month = month_ff;
    if (month_pend_ff) begin
      nxt_month = month_buf_ff;
    end else if (!is_bcd(month_ff, 8'h12) || month_ff == 8'h00) begin
      nxt_month = RST_MONTH;
    end else if (day_carry_ff) begin
      nxt_month = month_wrap ? 8'h01 : bcd_inc(month_ff);
    end
  end

  always_comb begin
    nxt_year = year_ff;
    if (year_pend_ff) begin
      nxt_year = year_buf_ff;
    end else if (!is_bcd(year_ff, 8'h99)) begin
      nxt_year = RST_YEAR;
    end else if (month_wrap && !month_pend_ff) begin
      nxt_year = year_wrap ? 8'h00 : bcd_inc(year_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      month_ff <= RST_MONTH;
      year_ff  <= RST_YEAR;
    end else if (slow_tick) begin
      month_ff <= nxt_month;
      year_ff  <= nxt_year;
    end
  end

  // bcd multiple of four: even tens need ones 0/4/8, odd tens need 2/6
  // no century rule, the count only spans 00 to 99
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  always_ff @(posedge clk) begin
    if (!resetn) begin
      leap_year <= 1'b1;
    end else begin
      leap_year <= is_leap(year_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      month_out <= RST_MONTH;
      year_out  <= RST_YEAR;
    end else begin
      month_out <= month_ff;
      year_out  <= year_ff;
    end
  end

  // ********************************************************
  // alarm registers and control
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alm_min_ff  <= RST_ALM_MIN;
      alm_wday_ff <= RST_ALM_WDAY;
      alm_hour_ff <= RST_ALM_HOUR12;
      fmt24_ff    <= 1'b0;
      irq_mask_ff <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_ALM_MIN:  alm_min_ff  <= bus.wdata & ALM_MIN_MASK;
        ADDR_ALM_WDAY: alm_wday_ff <= bus.wdata & ALM_WDAY_MASK;
        ADDR_ALM_HOUR: alm_hour_ff <= bus.wdata & ALM_HOUR_MASK;
        ADDR_CTRL: begin
          fmt24_ff <= bus.wdata[CTRL_FMT_BIT];
          // untouched 12h reset value follows the format as 00h
          if (bus.wdata[CTRL_FMT_BIT] && alm_hour_ff == RST_ALM_HOUR12) begin
            alm_hour_ff <= RST_ALM_HOUR24;
          end
        end
        ADDR_IRQ_MASK: irq_mask_ff <= bus.wdata[2:0];
        default: ;
      endcase
    end
  end

  // ********************************************************
  // alarm compare
  // ********************************************************
  logic min_ok, hour_ok, alarm_hit, alarm_prev_ff;

  assign min_ok = is_bcd(alm_min_ff, 8'h59);
  // 12h form: low five bits 01..12 plus pm flag in bit 5, giving 21..32
  assign hour_ok = fmt24_ff ? is_bcd(alm_hour_ff, 8'h23)
                 : (is_bcd({3'b000, alm_hour_ff[4:0]}, 8'h12)
                    && alm_hour_ff[4:0] != 5'h00);
  assign alarm_hit = min_ok && hour_ok && (now.minute == alm_min_ff)
                     && (now.hour == alm_hour_ff)
                     && alm_wday_ff[now.weekday];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      alarm_prev_ff <= 1'b0;
    end else begin
      alarm_prev_ff <= alarm_hit;
    end
  end

  // ********************************************************
  // interrupt status, read clears, set wins
  // ********************************************************
  logic [2:0] irq_set;
  logic       rd_stat;
  // a pending month write drops the carry, so no year wrap may be flagged either
  assign irq_set = {year_wrap && slow_tick && !year_pend_ff && !month_pend_ff,
                    month_wrap && slow_tick && !month_pend_ff,
                    alarm_hit && !alarm_prev_ff};
  assign rd_stat = bus.rd && (bus.addr == ADDR_IRQ_STAT);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (rd_stat ? 3'b000 : irq_stat_ff) | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((rd_stat ? 3'b000 : irq_stat_ff) | irq_set) & irq_mask_ff);
    end
  end

  // ********************************************************
  // read data, one cycle after the strobe
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_MONTH:    rdata <= month_ff;
        ADDR_YEAR:     rdata <= year_ff;
        ADDR_ALM_MIN:  rdata <= alm_min_ff;
        ADDR_ALM_HOUR: rdata <= alm_hour_ff;
        ADDR_ALM_WDAY: rdata <= alm_wday_ff;
        ADDR_CTRL:     rdata <= {4'h0, fmt24_ff, 3'b000};
        ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat_ff};
        ADDR_IRQ_MASK: rdata <= {5'h00, irq_mask_ff};
        default:       rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  a_month_reset: assert property (@(posedge clk) !resetn |=> month_ff == RST_MONTH)
    else $error("month not 01h after reset");
  a_year_reset: assert property (@(posedge clk) !resetn |=> year_ff == RST_YEAR && alm_min_ff == 8'h00 && alm_wday_ff == 8'h00)
    else $error("year or alarm not cleared by reset");
  a_month_write_lands: assert property (@(posedge clk) disable iff (!resetn)
    wr_month |=> month_pend_ff && month_buf_ff == $past(bus.wdata & MONTH_MASK))
    else $error("month write not transferred in time");
  a_month_step: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && day_carry_ff && !month_pend_ff && month_ff == 8'h12 |=> month_ff == 8'h01)
    else $error("month did not advance");
  a_year_step: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && month_wrap && !year_pend_ff && !month_pend_ff && year_ff == 8'h99 |=> year_ff == 8'h00)
    else $error("year did not advance on month wrap");
  a_write_beats_carry: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && month_pend_ff |=> month_ff == $past(month_buf_ff))
    else $error("carry disturbed written month");
  a_range_restore: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && !month_pend_ff && month_ff == 8'h13 |=> month_ff == RST_MONTH)
    else $error("bad month not restored");
  a_bad_min_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !min_ok |-> !alarm_hit)
    else $error("alarm with bad minute");
  a_bad_hour_quiet: assert property (@(posedge clk) disable iff (!resetn)
    fmt24_ff && alm_hour_ff == 8'h24 |-> !alarm_hit)
    else $error("alarm with bad hour");
  a_alarm_irq: assert property (@(posedge clk) disable iff (!resetn)
    alarm_hit && !alarm_prev_ff && irq_mask_ff[IRQ_ALARM_BIT] |=> irq)
    else $error("alarm did not raise interrupt");
  a_leap_check: assert property (@(posedge clk) disable iff (!resetn)
    year_ff == 8'h96 |=> leap_year)
    else $error("96 not a leap year");

  // ********************************************************
  // checks on counters and buffers
  // ********************************************************
  a_month_xfer_time: assert property (@(posedge clk) disable iff (!resetn)
    $rose(month_pend_ff) |-> ##[1:610] !month_pend_ff)
    else $error("month buffer not emptied within two ticks");
  a_year_write_lands: assert property (@(posedge clk) disable iff (!resetn)
    wr_year |=> year_pend_ff && year_buf_ff == $past(bus.wdata))
    else $error("year write not buffered");
  a_year_keeps_write: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && year_pend_ff |=> year_ff == $past(year_buf_ff))
    else $error("carry disturbed written year");
  a_year_restore: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && !year_pend_ff && !is_bcd(year_ff, 8'h99) |=> year_ff == RST_YEAR)
    else $error("bad year not restored");
  a_leap_four: assert property (@(posedge clk) disable iff (!resetn)
    year_ff == 8'h04 |=> leap_year)
    else $error("04 not a leap year");
  a_leap_other: assert property (@(posedge clk) disable iff (!resetn)
    year_ff == 8'h99 |=> !leap_year)
    else $error("99 taken as a leap year");
  a_carry_caught: assert property (@(posedge clk) disable iff (!resetn)
    day_carry && !slow_tick |=> day_carry_ff)
    else $error("day carry lost before tick");
  a_div_bound: assert property (@(posedge clk) disable iff (!resetn)
    div_ff <= SLOW_DIV_LAST)
    else $error("slow divider out of range");
  a_out_copy: assert property (@(posedge clk) disable iff (!resetn)
    month_out == $past(month_ff) && year_out == $past(year_ff))
    else $error("counter copies do not follow");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    alm_min_ff[7] == 1'b0 && alm_wday_ff[7] == 1'b0 && month_ff[7:5] == 3'b000)
    else $error("reserved bit set");

  // ********************************************************
  // checks on alarm registers and interrupts
  // ********************************************************
  a_min_write: assert property (@(posedge clk) disable iff (!resetn)
    bus.wr && bus.addr == ADDR_ALM_MIN |=> alm_min_ff == $past(bus.wdata & ALM_MIN_MASK))
    else $error("alarm minute write lost");
  a_wday_write: assert property (@(posedge clk) disable iff (!resetn)
    bus.wr && bus.addr == ADDR_ALM_WDAY |=> alm_wday_ff == $past(bus.wdata & ALM_WDAY_MASK))
    else $error("alarm weekday write lost");
  a_hour_write: assert property (@(posedge clk) disable iff (!resetn)
    bus.wr && bus.addr == ADDR_ALM_HOUR |=> alm_hour_ff == $past(bus.wdata & ALM_HOUR_MASK))
    else $error("alarm hour write lost");
  a_hour_follows_fmt: assert property (@(posedge clk) disable iff (!resetn)
    bus.wr && bus.addr == ADDR_CTRL && bus.wdata[CTRL_FMT_BIT] && alm_hour_ff == RST_ALM_HOUR12
    |=> alm_hour_ff == RST_ALM_HOUR24)
    else $error("alarm hour did not follow format");
  a_pm_no_zero: assert property (@(posedge clk) disable iff (!resetn)
    !fmt24_ff && alm_hour_ff[4:0] == 5'h00 |-> !alarm_hit)
    else $error("alarm with zero hour in 12h form");
  a_wday_gate: assert property (@(posedge clk) disable iff (!resetn)
    !alm_wday_ff[now.weekday] |-> !alarm_hit)
    else $error("alarm on a disabled weekday");
  a_alarm_status: assert property (@(posedge clk) disable iff (!resetn)
    irq_set[IRQ_ALARM_BIT] |=> irq_stat_ff[IRQ_ALARM_BIT])
    else $error("alarm event not latched");
  a_month_wrap_flag: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && month_wrap && !month_pend_ff |=> irq_stat_ff[IRQ_MONTH_BIT])
    else $error("month wrap not latched");
  a_year_wrap_flag: assert property (@(posedge clk) disable iff (!resetn)
    slow_tick && year_wrap && !year_pend_ff && !month_pend_ff |=> irq_stat_ff[IRQ_YEAR_BIT])
    else $error("year wrap not latched");
  a_irq_read_clear: assert property (@(posedge clk) disable iff (!resetn)
    rd_stat && irq_set == 3'b000 |=> irq_stat_ff == 3'b000)
    else $error("status not cleared by read");
  a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
    bus.wr && bus.addr == ADDR_IRQ_MASK |=> irq_mask_ff == $past(bus.wdata[2:0]))
    else $error("mask write lost");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
    !$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule

// ### rtcca_pkg.sv
// package: constants and types for the calendar and alarm part of the real-time clock
// Function
// - The month counter counts 1 to 12 in BCD and advances on each day counter overflow.
// - The year counter counts 0 to 99 in BCD and advances on each month counter overflow.
// - A software write to month or year goes to a holding buffer and reaches the counter within two slow-clock ticks.
// - A carry arriving while month or year is being written is dropped and the written value is loaded.
// - Software may write out-of-range BCD, and an out-of-range count returns to a normal value after one counting period.
// - Year values divisible by four, 00 through 96, are leap years for the length of February.
// - Reset loads the month counter with 01h.
// - Reset clears the year counter, the alarm minute and the alarm weekday registers to 00h.
// - The alarm hour resets to 12h and reads 00h once the hour-format select bit is set to 1 after reset.
// - An alarm minute outside BCD 00 to 59 never produces an alarm match.
// - An alarm hour outside the range for the hour format suppresses alarm detection.
// - In 12-hour format bit 5 of the alarm hour is the AM/PM flag instead of a tens digit.
// - The alarm weekday register has one enable bit per day of the week.
package rtcca_pkg;

  localparam logic [19:0] ADDR_MONTH     = 20'hfff97;
  localparam logic [19:0] ADDR_YEAR      = 20'hfff98;
  localparam logic [19:0] ADDR_ALM_MIN   = 20'hfff9a;
  localparam logic [19:0] ADDR_ALM_HOUR  = 20'hfff9b;
  localparam logic [19:0] ADDR_ALM_WDAY  = 20'hfff9c;
  localparam logic [19:0] ADDR_CTRL      = 20'hfff9d;
  localparam logic [19:0] ADDR_IRQ_STAT  = 20'hfff9e;
  localparam logic [19:0] ADDR_IRQ_MASK  = 20'hfff9f;

  localparam logic [7:0] RST_MONTH      = 8'h01;
  localparam logic [7:0] RST_YEAR       = 8'h00;
  localparam logic [7:0] RST_ALM_MIN    = 8'h00;
  localparam logic [7:0] RST_ALM_WDAY   = 8'h00;
  localparam logic [7:0] RST_ALM_HOUR12 = 8'h12;
  localparam logic [7:0] RST_ALM_HOUR24 = 8'h00;

  localparam logic [7:0] MONTH_MASK     = 8'h1f;
  localparam logic [7:0] ALM_MIN_MASK   = 8'h7f;
  localparam logic [7:0] ALM_WDAY_MASK  = 8'h7f;
  localparam logic [7:0] ALM_HOUR_MASK  = 8'h3f;
  localparam int         CTRL_FMT_BIT   = 3;
  localparam int         PM_BIT         = 5;

  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_MONTH_BIT = 1;
  localparam int IRQ_YEAR_BIT  = 2;

  // slow clock 32.768 kHz from 10 MHz: enable every 305 cycles (nearest whole count)
  localparam int CLK_HZ      = 10000000;
  localparam int SLOW_HZ     = 32768;
  localparam int SLOW_DIV    = CLK_HZ / SLOW_HZ;
  localparam int XFER_TICKS  = 2;
  localparam logic [8:0] SLOW_DIV_LAST = 9'(SLOW_DIV - 1);

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } rtcca_bus_s;

  typedef struct packed {
    logic [7:0] minute;
    logic [7:0] hour;
    logic [2:0] weekday;
  } rtcca_time_s;

endpackage

// ### tb_rtcca_calendar.sv
// self-checking testbench for the calendar and alarm block
`timescale 1ns/100ps
module tb_rtcca_calendar;
  import rtcca_pkg::*;
  // ****************************************
  // signals and design instance
  // ****************************************
  logic              clk;
  logic              resetn;
  rtcca_bus_s        bus;
  logic [7:0]        rdata;
  logic              day_carry;
  rtcca_time_s       now;
  logic [7:0]        month_out;
  logic [7:0]        year_out;
  logic              leap_year;
  logic              irq;
  int                mismatches;
  int                n_checks;

  rtcca_calendar rtcca_calendar_inst (
    .clk       (clk),
    .resetn    (resetn),
    .bus       (bus),
    .rdata     (rdata),
    .day_carry (day_carry),
    .now       (now),
    .month_out (month_out),
    .year_out  (year_out),
    .leap_year (leap_year),
    .irq       (irq)
  );

  always #50 clk = ~clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string name, input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask

  // counters move only on slow ticks; two ticks is the longest a write may take
  task automatic tick_wait;
    repeat (2 * SLOW_DIV + 2) @(posedge clk);
  endtask

  task automatic alarm(input logic [7:0] m, input logic [7:0] h, input logic [2:0] d,
                       input logic exp);
    @(posedge clk) now <= '{minute: 8'h00, hour: 8'h00, weekday: 3'd0};
    repeat (3) @(posedge clk);
    now <= '{minute: m, hour: h, weekday: d};
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
    #1;
    chk("irq alarm", {7'h00, exp}, {7'h00, irq});
    rchk("status alarm", ADDR_IRQ_STAT, exp ? 8'h01 : 8'h00);
    @(posedge clk) now <= '{minute: 8'h00, hour: 8'h00, weekday: 3'd0};
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rchk("month", ADDR_MONTH, 8'h01);
    rchk("year", ADDR_YEAR, 8'h00);
    rchk("alarm minute", ADDR_ALM_MIN, 8'h00);
    rchk("alarm weekday", ADDR_ALM_WDAY, 8'h00);
    rchk("alarm hour", ADDR_ALM_HOUR, 8'h12);
    rchk("unmapped", 20'hfff99, 8'h00);
    chk("leap", 8'h01, {7'h00, leap_year});
    chk("irq idle", 8'h00, {7'h00, irq});
  endtask

  task automatic t_reserved;
    wr(ADDR_ALM_MIN, 8'hff);
    rchk("alarm minute mask", ADDR_ALM_MIN, 8'h7f);
    wr(ADDR_ALM_WDAY, 8'hff);
    rchk("weekday mask", ADDR_ALM_WDAY, 8'h7f);
    wr(ADDR_ALM_WDAY, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    rchk("alarm hour 24h", ADDR_ALM_HOUR, 8'h00);
  endtask

  task automatic t_wrap;
    wr(ADDR_IRQ_MASK, 8'h07);
    wr(ADDR_MONTH, 8'h12);
    wr(ADDR_YEAR, 8'h99);
    tick_wait();
    rchk("month load", ADDR_MONTH, 8'h12);
    rchk("year load", ADDR_YEAR, 8'h99);
    chk("leap 99", 8'h00, {7'h00, leap_year});
    @(posedge clk) day_carry <= 1'b1;
    @(posedge clk) day_carry <= 1'b0;
    tick_wait();
    rchk("month wrap", ADDR_MONTH, 8'h01);
    rchk("year wrap", ADDR_YEAR, 8'h00);
    chk("month out", 8'h01, month_out);
    chk("year out", 8'h00, year_out);
    chk("irq wrap", 8'h01, {7'h00, irq});
    rchk("status wrap", ADDR_IRQ_STAT, 8'h06);
    rchk("status cleared", ADDR_IRQ_STAT, 8'h00);
    chk("irq cleared", 8'h00, {7'h00, irq});
  endtask

  // a carry arriving together with the write must not bump the loaded value
  task automatic t_carry_write;
    @(posedge clk);
    bus <= '{addr: ADDR_MONTH, wdata: 8'h05, wr: 1'b1, rd: 1'b0};
    day_carry <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    day_carry <= 1'b0;
    tick_wait();
    rchk("month carry drop", ADDR_MONTH, 8'h05);
    rchk("year carry drop", ADDR_YEAR, 8'h00);
  endtask

  task automatic t_leap;
    logic [7:0] yrs [3] = '{8'h04, 8'h03, 8'h96};
    logic [7:0] lp [3] = '{8'h01, 8'h00, 8'h01};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_YEAR, yrs[i]);
      tick_wait();
      chk("leap table", lp[i], {7'h00, leap_year});
    end
  endtask

  task automatic t_range;
    wr(ADDR_MONTH, 8'h13);
    wr(ADDR_YEAR, 8'ha5);
    tick_wait();
    tick_wait();
    rchk("month restore", ADDR_MONTH, 8'h01);
    rchk("year restore", ADDR_YEAR, 8'h00);
    rchk("status flush", ADDR_IRQ_STAT, 8'h00);
  endtask

  task automatic t_alarm;
    wr(ADDR_ALM_MIN, 8'h30);
    wr(ADDR_ALM_HOUR, 8'h10);
    wr(ADDR_ALM_WDAY, 8'h04);
    alarm(8'h30, 8'h10, 3'd2, 1'b1);
    alarm(8'h30, 8'h10, 3'd3, 1'b0);
    wr(ADDR_ALM_MIN, 8'h60);
    alarm(8'h60, 8'h10, 3'd2, 1'b0);
    wr(ADDR_ALM_MIN, 8'h30);
    wr(ADDR_ALM_HOUR, 8'h24);
    alarm(8'h30, 8'h24, 3'd2, 1'b0);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_ALM_HOUR, 8'h21);
    alarm(8'h30, 8'h21, 3'd2, 1'b1);
    alarm(8'h30, 8'h01, 3'd2, 1'b0);
    // masked: status still latches, output stays low
    wr(ADDR_IRQ_MASK, 8'h06);
    now <= '{minute: 8'h30, hour: 8'h21, weekday: 3'd2};
    repeat (20) @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    rchk("status masked", ADDR_IRQ_STAT, 8'h01);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    bus = '{addr: 20'h00000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    day_carry = 1'b0;
    now = '{minute: 8'h00, hour: 8'h00, weekday: 3'd0};
    mismatches = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_reserved();
    t_wrap();
    t_carry_write();
    t_leap();
    t_range();
    t_alarm();
    summarize();
  end

  // about 5100 cycles expected; generous margin before calling it a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[ERR] watchdog expected done seen timeout");
    summarize();
  end
endmodule
